/* logic/tasc_core.sv */
// Thermometer core: gated measurement, alarm compare, identity ROM,
// scratchpad with CRC and nonvolatile trigger bytes.
// Assumes a front end that handles reset, presence and time slots and
// hands over whole command and data bytes as one-cycle pulses on clk.
`timescale 1ns/1ps
module tasc_core
  import tasc_pkg::*;
#(
  parameter logic [7:0]  FAMILY_CODE = 8'h5a,          // Arbitrary value.
  parameter logic [47:0] SERIAL_NUM  = 48'h0123456789ab // Arbitrary value.
) (
  input  wire logic        clk,           // Core clock, 40 MHz.
  input  wire logic        arst_n,        // Asynchronous reset, active low.
  input  wire logic        ce,            // Clock enable; low freezes state.
  input  wire logic        osc_ref,       // Low tempco oscillator pin.
  input  wire logic        osc_gate,      // High tempco oscillator pin.
  input  wire logic        bus_reset,     // Bus reset seen, pulse.
  input  wire logic        rom_done,      // ROM command finished, pulse.
  input  wire logic        cmd_valid,     // Function command byte, pulse.
  input  wire logic [7:0]  cmd_code,      // Function command code.
  input  wire logic        wr_valid,      // Data byte written, pulse.
  input  wire logic [7:0]  wr_data,       // Data byte from master.
  input  wire logic        rd_req,        // Next read byte wanted, pulse.
  output logic [7:0]       rd_data,       // Read byte, registered.
  output logic             rd_valid,      // Read byte ready, pulse.
  output logic [63:0]      rom_id,        // Identity ROM, registered.
  output logic             alarm_respond, // Joins alarm search.
  output logic             busy,          // Conversion running.
  output logic             cmd_refused    // Command refused for lack of ROM access, pulse.
);
  // Synchroniser chains; only the second stage feeds logic.
  logic [1:0]  ref_sync;      // Reference oscillator sync.
  logic [1:0]  gate_sync;     // Gate oscillator sync.
  logic        ref_d;         // Delayed reference for edges.
  logic        gate_d;        // Delayed gate for edges.
  logic        ref_rise;      // Reference count enable.
  logic        gate_rise;     // Gate count enable.
  // Measurement state.
  tasc_state_t state;         // Sequencer state.
  logic [7:0]  meas_cnt;      // Down counter.
  logic [7:0]  slope;         // Slope accumulator.
  logic [15:0] gate_cnt;      // Gate edge counter.
  logic [8:0]  temp;          // 9-bit signed result.
  logic [7:0]  resid;         // Residual reference count.
  logic [7:0]  cpd;           // Counts per degree.
  logic        alarm;         // Internal alarm flag.
  logic        meas_end;      // Gate closes this cycle.
  // Memory state.
  logic [7:0]  high_alarm_trigger; // Scratchpad high copy.
  logic [7:0]  low_alarm_trigger;  // Scratchpad low copy.
  logic [7:0]  nv_high;       // Nonvolatile high byte.
  logic [7:0]  nv_low;        // Nonvolatile low byte.
  logic        por_load;      // Power-on reload pending.
  logic        rom_ok;        // ROM protocol satisfied.
  logic        wr_act;        // Scratchpad write open.
  logic        wr_second;     // Next write is the low byte.
  logic        rd_act;        // Scratchpad read open.
  logic [3:0]  rd_idx;        // Next byte to read.
  logic [7:0]  rd_crc;        // Running scratchpad CRC.
  logic [7:0]  scr_byte;      // Selected scratchpad byte.
  logic        cmd_ok;        // Command may be taken.
  logic [7:0]  temp_hi;       // Sign-extended upper byte.
  logic [7:0]  temp_whole;    // Whole degrees for compare.
  // Two flip-flops per pin, then one more stage for edge detect.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_sync  <= 2'h0;
      gate_sync <= 2'h0;
      ref_d     <= 1'b0;
      gate_d    <= 1'b0;
    end else if (ce) begin
      ref_sync  <= {ref_sync[0], osc_ref};
      gate_sync <= {gate_sync[0], osc_gate};
      ref_d     <= ref_sync[1];
      gate_d    <= gate_sync[1];
    end
  end
  assign ref_rise  = ref_sync[1] & ~ref_d;
  assign gate_rise = gate_sync[1] & ~gate_d;
  // The gate closes on the last counted edge of the sensitive oscillator.
  assign meas_end  = (state == TASC_CONV) && gate_rise && (gate_cnt == GATE_ONE);
  // Function commands are taken only once the ROM protocol is satisfied.
  assign cmd_ok = cmd_valid && rom_ok;
  // ROM gate: a bus reset revokes access, a finished ROM command grants it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_ok      <= 1'b0;
      cmd_refused <= 1'b0;
    end else if (ce) begin
      cmd_refused <= cmd_valid && !rom_ok;
      if (rom_done) begin
        rom_ok <= 1'b1;
      end else if (bus_reset) begin
        rom_ok <= 1'b0;
      end
    end
  end
  // Measurement sequencer.  A convert during a conversion is ignored.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= TASC_IDLE;
      meas_cnt <= BASE_COUNT;
      slope    <= SLOPE_INIT;
      gate_cnt <= GATE_LEN;
      temp     <= TEMP_BASE;
    end else if (ce) begin
      unique case (state)
        TASC_IDLE: begin
          if (cmd_ok && cmd_code == CMD_CONVERT) begin
            state    <= TASC_CONV;
            meas_cnt <= BASE_COUNT;
            temp     <= TEMP_BASE;
            slope    <= SLOPE_INIT;
            gate_cnt <= GATE_LEN;
          end
        end
        TASC_CONV: begin
          if (gate_rise) begin
            gate_cnt <= gate_cnt - GATE_ONE;
          end
          if (meas_end) begin
            state <= TASC_IDLE;
          end else if (ref_rise) begin
            if (meas_cnt == CNT_ZERO) begin
              // Clamp at the top of range so the code never wraps.
              if (temp != TEMP_MAX) begin
                temp <= temp + TEMP_ONE;
              end
              meas_cnt <= slope;
              slope    <= slope + SLOPE_INC;
            end else begin
              meas_cnt <= meas_cnt - CNT_ONE;
            end
          end
        end
      endcase
    end
  end
  // Sign extension and whole-degree view of the result.
  assign temp_hi    = {8{temp[8]}};
  assign temp_whole = temp[8:1];
  // Gate end: keep counters for interpolation and recompute the alarm.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resid <= CNT_ZERO;
      cpd   <= SLOPE_INIT;
      alarm <= 1'b0;
    end else if (ce && meas_end) begin
      resid <= meas_cnt;
      cpd   <= slope;
      // Stored trigger bytes decide the alarm, not the scratchpad copies.
      alarm <= ($signed(temp_whole) > $signed(nv_high)) ||
               ($signed(temp_whole) < $signed(nv_low));
    end
  end
  assign alarm_respond = alarm;
  assign busy          = (state == TASC_CONV);
  // Trigger copies and nonvolatile storage.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      por_load           <= 1'b1;
      nv_high            <= NV_HI_RST;
      nv_low             <= NV_LO_RST;
      high_alarm_trigger <= NV_HI_RST;
      low_alarm_trigger  <= NV_LO_RST;
      wr_act             <= 1'b0;
      wr_second          <= 1'b0;
    end else if (ce) begin
      por_load <= 1'b0;
      if (por_load || (cmd_ok && cmd_code == CMD_RECALL)) begin
        high_alarm_trigger <= nv_high;
        low_alarm_trigger  <= nv_low;
      end else if (wr_act && wr_valid) begin
        if (wr_second) begin
          low_alarm_trigger <= wr_data;
          wr_act            <= 1'b0;
        end else begin
          high_alarm_trigger <= wr_data;
          wr_second          <= 1'b1;
        end
      end
      if (cmd_ok && cmd_code == CMD_WRITE_SCR) begin
        wr_act    <= 1'b1;
        wr_second <= 1'b0;
      end else if (bus_reset) begin
        wr_act <= 1'b0;
      end
      if (cmd_ok && cmd_code == CMD_COPY_SCR) begin
        nv_high <= high_alarm_trigger;
        nv_low  <= low_alarm_trigger;
      end
    end
  end
  // Scratchpad byte selection by read index.
  always_comb begin
    unique case (rd_idx)
      SCR_TEMP_LO: scr_byte = temp[7:0];
      SCR_TEMP_HI: scr_byte = temp_hi;
      SCR_HI_TRIG: scr_byte = high_alarm_trigger;
      SCR_LO_TRIG: scr_byte = low_alarm_trigger;
      SCR_UNUSED0: scr_byte = BYTE_ONES;
      SCR_UNUSED1: scr_byte = BYTE_ONES;
      SCR_RESID:   scr_byte = resid;
      SCR_CPD:     scr_byte = cpd;
      SCR_CRC:     scr_byte = rd_crc;
      default:     scr_byte = BYTE_ONES;
    endcase
  end
  // Scratchpad read; the CRC is offered and never checked here.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_act   <= 1'b0;
      rd_idx   <= SCR_TEMP_LO;
      rd_crc   <= CRC_INIT;
      rd_data  <= BYTE_ONES;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= 1'b0;
      if (cmd_ok && cmd_code == CMD_READ_SCR) begin
        rd_act <= 1'b1;
        rd_idx <= SCR_TEMP_LO;
        rd_crc <= CRC_INIT;
      end else if (bus_reset) begin
        rd_act <= 1'b0;
      end else if (rd_req) begin
        rd_valid <= 1'b1;
        rd_data  <= rd_act ? scr_byte : BYTE_ONES;
        if (rd_act && rd_idx != SCR_CRC) begin
          rd_crc <= tasc_crc_byte(rd_crc, scr_byte);
        end
        if (rd_idx != SCR_CRC) begin
          rd_idx <= rd_idx + SCR_IDX_ONE;
        end else begin
          rd_act <= 1'b0;
        end
      end
    end
  end
  // Identity ROM; its CRC comes from the same generator.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_id <= 64'h0;
    end else if (ce) begin
      rom_id <= {tasc_crc_byte(tasc_crc_byte(tasc_crc_byte(tasc_crc_byte(
                 tasc_crc_byte(tasc_crc_byte(tasc_crc_byte(CRC_INIT, FAMILY_CODE),
                 SERIAL_NUM[7:0]), SERIAL_NUM[15:8]), SERIAL_NUM[23:16]),
                 SERIAL_NUM[31:24]), SERIAL_NUM[39:32]), SERIAL_NUM[47:40]),
                 SERIAL_NUM, FAMILY_CODE};
    end
  end
  // Sequence helpers for the checks below.
  sequence s_convert;
    ce && cmd_ok && cmd_code == CMD_CONVERT && state == TASC_IDLE;
  endsequence
  sequence s_gate_close;
    ce && meas_end;
  endsequence
  property p_start;
    @(posedge clk) disable iff (!arst_n) s_convert |=> temp == TEMP_BASE && busy;
  endproperty
  a_start: assert property (p_start) else $error("Conversion preset wrong.");
  property p_step;
    @(posedge clk) disable iff (!arst_n)
      ce && busy && !meas_end && ref_rise && meas_cnt == CNT_ZERO && temp != TEMP_MAX
      |=> temp == $past(temp) + TEMP_ONE && meas_cnt == $past(slope);
  endproperty
  a_step: assert property (p_step) else $error("Zero crossing step wrong.");
  property p_resid;
    @(posedge clk) disable iff (!arst_n)
      s_gate_close |=> resid == $past(meas_cnt) && cpd == $past(slope) && !busy;
  endproperty
  a_resid: assert property (p_resid) else $error("Residual not kept.");
  property p_alarm;
    @(posedge clk) disable iff (!arst_n)
      s_gate_close ##1 1'b1 |-> alarm_respond ==
        (($signed(temp_whole) > $signed(nv_high)) || ($signed(temp_whole) < $signed(nv_low)));
  endproperty
  a_alarm: assert property (p_alarm) else $error("Alarm flag wrong.");
  property p_refuse;
    @(posedge clk) disable iff (!arst_n)
      ce && cmd_valid && !rom_ok && state == TASC_IDLE |=> !busy && cmd_refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("Command not refused.");
  property p_rom_crc;
    @(posedge clk) disable iff (!arst_n)
      ce ##1 1'b1 |-> tasc_crc_byte(tasc_crc_byte(tasc_crc_byte(tasc_crc_byte(
        tasc_crc_byte(tasc_crc_byte(tasc_crc_byte(tasc_crc_byte(CRC_INIT,
        rom_id[7:0]), rom_id[15:8]), rom_id[23:16]), rom_id[31:24]),
        rom_id[39:32]), rom_id[47:40]), rom_id[55:48]), rom_id[63:56]) == CRC_INIT;
  endproperty
  a_rom_crc: assert property (p_rom_crc) else $error("ROM CRC check fails.");
  property p_unused;
    @(posedge clk) disable iff (!arst_n)
      ce && rd_req && rd_act && !bus_reset && !cmd_ok &&
      (rd_idx == SCR_UNUSED0 || rd_idx == SCR_UNUSED1) |=> rd_valid && rd_data == BYTE_ONES;
  endproperty
  a_unused: assert property (p_unused) else $error("Unused byte not ones.");
  property p_copy;
    @(posedge clk) disable iff (!arst_n)
      ce && !(cmd_ok && cmd_code == CMD_COPY_SCR) |=> $stable(nv_high) && $stable(nv_low);
  endproperty
  a_copy: assert property (p_copy) else $error("Storage changed without copy.");
  // The upper temperature byte as read out must be eight copies of the sign.
  property p_sign;
    @(posedge clk) disable iff (!arst_n)
      ce && rd_req && rd_act && !bus_reset && !cmd_ok && rd_idx == SCR_TEMP_HI
      |=> rd_valid && rd_data == {8{$past(temp[8])}};
  endproperty
  a_sign: assert property (p_sign) else $error("Upper byte not sign copy.");
endmodule

/* logic/tasc_pkg.sv */
// Constants shared by the thermometer, alarm and scratchpad core.
// Assumes a byte-level bus front end that decodes commands and bytes.
package tasc_pkg;
  // Command codes seen on the byte interface.
  localparam logic [7:0] CMD_CONVERT   = 8'h44;
  localparam logic [7:0] CMD_WRITE_SCR = 8'h4e;
  localparam logic [7:0] CMD_READ_SCR  = 8'hbe;
  localparam logic [7:0] CMD_COPY_SCR  = 8'h48;
  localparam logic [7:0] CMD_RECALL    = 8'hb8;
  localparam logic [7:0] CMD_ALARM_SRC = 8'hec;
  // Temperature codes in half-degree steps, 9-bit signed.
  localparam logic [8:0] TEMP_BASE = 9'h192;
  localparam logic [8:0] TEMP_MAX  = 9'h0c8;
  localparam logic [8:0] TEMP_ONE  = 9'h001;
  // Counter preset for the base temperature and slope start.
  localparam logic [7:0] BASE_COUNT = 8'h40;
  localparam logic [7:0] SLOPE_INIT = 8'h10;
  localparam logic [7:0] SLOPE_INC  = 8'h01;
  localparam logic [7:0] CNT_ZERO   = 8'h00;
  localparam logic [7:0] CNT_ONE    = 8'h01;
  // Gate length in edges of the temperature-sensitive oscillator.
  localparam logic [15:0] GATE_LEN = 16'h0400;
  localparam logic [15:0] GATE_ONE = 16'h0001;
  // Scratchpad byte positions and fixed contents.
  localparam logic [3:0] SCR_TEMP_LO = 4'h0;
  localparam logic [3:0] SCR_TEMP_HI = 4'h1;
  localparam logic [3:0] SCR_HI_TRIG = 4'h2;
  localparam logic [3:0] SCR_LO_TRIG = 4'h3;
  localparam logic [3:0] SCR_UNUSED0 = 4'h4;
  localparam logic [3:0] SCR_UNUSED1 = 4'h5;
  localparam logic [3:0] SCR_RESID   = 4'h6;
  localparam logic [3:0] SCR_CPD     = 4'h7;
  localparam logic [3:0] SCR_CRC     = 4'h8;
  localparam logic [3:0] SCR_IDX_ONE = 4'h1;
  localparam logic [7:0] BYTE_ONES   = 8'hff;
  // Reflected form of x^8 + x^5 + x^4 + 1 for LSB-first shifting.
  localparam logic [7:0] CRC_POLY = 8'h8c;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // Nonvolatile trigger contents after first power-up.
  localparam logic [7:0] NV_HI_RST = 8'h7d;
  localparam logic [7:0] NV_LO_RST = 8'hc9;
  // Measurement sequencer states.
  typedef enum logic [0:0] {TASC_IDLE, TASC_CONV} tasc_state_t;
  // One CRC step over a byte, least significant bit first.
  function automatic logic [7:0] tasc_crc_byte(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage

/* sim/tasc_master_model.sv */
// Bus master model: drives the core's byte interface as the front end
// would once reset, ROM selection and time slots are dealt with.
// Assumes the bench supplies clk and judges the bytes returned.
`timescale 1ns/1ps
module tasc_master_model
  import tasc_pkg::*;
(
  input  wire logic       clk,       // Core clock.
  input  wire logic [7:0] rd_data,   // Read byte from the core.
  input  wire logic       rd_valid,  // Read byte strobe.
  output logic            bus_reset, // Bus reset pulse.
  output logic            rom_done,  // ROM command finished pulse.
  output logic            cmd_valid, // Function command pulse.
  output logic [7:0]      cmd_code,  // Function command code.
  output logic            wr_valid,  // Data byte pulse.
  output logic [7:0]      wr_data,   // Data byte.
  output logic            rd_req     // Read byte request pulse.
);
  // Everything idles low so nothing is requested during reset.
  initial begin
    {bus_reset, rom_done, cmd_valid, wr_valid, rd_req} = 5'h00;
    cmd_code = 8'h00;
    wr_data  = 8'h00;
  end

  // One-cycle strobe: 0 bus reset, 1 ROM done, 2 command, else data.
  // Data is held with the strobe so the core sees a stable byte.
  task automatic st(input int kind, input logic [7:0] d);
    @(negedge clk);
    cmd_code = d;
    wr_data  = d;
    case (kind)
      0: bus_reset = 1'b1;
      1: rom_done = 1'b1;
      2: cmd_valid = 1'b1;
      default: wr_valid = 1'b1;
    endcase
    @(negedge clk);
    {bus_reset, rom_done, cmd_valid, wr_valid} = 4'h0;
  endtask

  // Requests one byte and takes it when the strobe shows; bounded wait.
  task automatic read_byte(output logic [7:0] b, output bit ok);
    @(negedge clk);
    rd_req = 1'b1;
    @(negedge clk);
    rd_req = 1'b0;
    ok = 1'b0;
    b = 8'h00;
    for (int i = 0; i < 3 && !ok; i++) begin
      if (rd_valid === 1'b1) begin
        b = rd_data;
        ok = 1'b1;
      end else begin
        @(negedge clk);
      end
    end
  endtask

  // Bit-serial generator started from zero, fed LSB first; feeding the
  // stored CRC after its data must leave the register at zero.
  function automatic logic [7:0] crc_bits(input logic [71:0] v, input int n);
    logic [7:0] c;
    logic       fb;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      fb = c[0] ^ v[i];
      c = c >> 1;
      if (fb) c = c ^ CRC_POLY;
    end
    return c;
  endfunction

  // Interpolated reading; the half-degree bit is dropped first.
  function automatic real fine_temp(input logic [8:0] t, input logic [7:0] r,
                                    input logic [7:0] s);
    return $itor($signed(t[8:1])) - 0.25 + $itor(s - r) / $itor(s);
  endfunction
endmodule

/* sim/thermometer_alarm_scratchpad_core_tb_top.sv */
// Self-checking bench for the thermometer core: it pulses the two
// oscillators and talks to the core through the master model.
// Assumes the package, core and master model are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module thermometer_alarm_scratchpad_core_tb_top
  import tasc_pkg::*;
;
  localparam logic [7:0]  FAM = 8'h3c;            // Arbitrary value.
  localparam logic [47:0] SER = 48'h0badcafe1234; // Arbitrary value.
  logic        clk, arst_n, ce, osc_ref, osc_gate; // Bench-driven inputs.
  logic        bus_reset, rom_done, cmd_valid, wr_valid, rd_req; // Model strobes.
  logic [7:0]  cmd_code, wr_data, rd_data;        // Byte lanes.
  logic        rd_valid, alarm_respond, busy, cmd_refused; // Core flags.
  logic [63:0] rom_id;                            // Identity ROM.
  logic [7:0]  nv_hi, nv_lo;                      // Expected storage.
  logic [7:0]  rb [0:9];                          // Bytes read back.
  int          err_total, cmp_count;              // Tallies.

  // 40 MHz clock.
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  tasc_core #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER)) tasc_core_i (
    .clk(clk), .arst_n(arst_n), .ce(ce), .osc_ref(osc_ref), .osc_gate(osc_gate),
    .bus_reset(bus_reset), .rom_done(rom_done), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .rom_id(rom_id),
    .alarm_respond(alarm_respond), .busy(busy), .cmd_refused(cmd_refused));

  tasc_master_model tasc_master_model_i (
    .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .bus_reset(bus_reset),
    .rom_done(rom_done), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req));

  // The only exit: counts, verdict, end of run.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Reads n bytes; a missing strobe counts as a failure and ends the run.
  task automatic read_scr(input int n);
    bit ok;
    for (int i = 0; i < n; i++) begin
      tasc_master_model_i.read_byte(rb[i], ok);
      `CHK(ok, 1'b1)
      if (!ok) tally_and_finish();
    end
  endtask

  // Bounded wait for busy to reach a level.
  task automatic wait_busy(input logic v, input int bound);
    for (int i = 0; i < bound && busy !== v; i++) @(negedge clk);
    `CHK(busy, v)
    if (busy !== v) tally_and_finish();
  endtask

  // One-cycle-high pulses on one oscillator; slow enough for the sync.
  task automatic osc_pulses(input int n, input bit gate);
    repeat (n) begin
      @(negedge clk);
      if (gate) osc_gate = 1'b1;
      else osc_ref = 1'b1;
      @(negedge clk);
      osc_gate = 1'b0;
      osc_ref = 1'b0;
    end
  endtask

  // Reset values, then identity layout and its CRC.
  task automatic test_reset_rom();
    `CHK(rom_id, 64'h0)
    `CHK(rd_data, BYTE_ONES)
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(rom_id[55:0], {SER, FAM})
    `CHK(rom_id[63:56], tasc_master_model_i.crc_bits({8'h00, rom_id}, 56))
    `CHK(tasc_master_model_i.crc_bits({8'h00, rom_id}, 64), CRC_INIT)
    $display("test_reset_rom done");
  endtask

  // Commands and reads before any ROM command are turned away.
  task automatic test_refuse();
    logic seen;
    tasc_master_model_i.st(2, CMD_CONVERT);
    seen = 1'b0;
    repeat (3) begin
      seen = seen | (cmd_refused === 1'b1);
      @(negedge clk);
    end
    `CHK(seen, 1'b1)
    `CHK(busy, 1'b0)
    read_scr(1);
    `CHK(rb[0], BYTE_ONES)
    $display("test_refuse done");
  endtask

  // Conversion with n reference edges, then full scratchpad read.
  task automatic test_measure(input int n, input logic [15:0] code);
    logic [8:0] t;
    logic [7:0] r, s;
    logic       al;
    t = TEMP_BASE;
    r = BASE_COUNT;
    s = SLOPE_INIT;
    // An edge that finds the counter already at zero steps the reading.
    repeat (n) begin
      if (r == CNT_ZERO) begin
        if (t != TEMP_MAX) t = t + TEMP_ONE;
        r = s;
        s = s + SLOPE_INC;
      end else begin
        r = r - CNT_ONE;
      end
    end
    al = ($signed(t[8:1]) > $signed(nv_hi)) || ($signed(t[8:1]) < $signed(nv_lo));
    tasc_master_model_i.st(1, 8'h00);
    tasc_master_model_i.st(2, CMD_CONVERT);
    wait_busy(1'b1, 4);
    osc_pulses(n, 1'b0);
    osc_pulses(int'(GATE_LEN), 1'b1);
    wait_busy(1'b0, 8);
    `CHK(alarm_respond, al)
    tasc_master_model_i.st(1, 8'h00);
    tasc_master_model_i.st(2, CMD_READ_SCR);
    read_scr(9);
    `CHK({rb[1], rb[0]}, code)
    `CHK({rb[1], rb[0]}, {{7{t[8]}}, t})
    `CHK({rb[3], rb[2]}, {nv_lo, nv_hi})
    `CHK({rb[5], rb[4]}, 16'hffff)
    `CHK({rb[7], rb[6]}, {s, r})
    `CHK(rb[8], tasc_master_model_i.crc_bits({rb[7], rb[6], rb[5], rb[4],
         rb[3], rb[2], rb[1], rb[0]}, 64))
    `CHK(tasc_master_model_i.crc_bits({rb[8], rb[7], rb[6], rb[5], rb[4],
         rb[3], rb[2], rb[1], rb[0]}, 72), CRC_INIT)
    $display("test_measure done, fine %f", tasc_master_model_i.fine_temp(t, r, s));
  endtask

  // New triggers stored by copy; a later write without copy is undone by recall.
  task automatic test_triggers();
    tasc_master_model_i.st(1, 8'h00);
    tasc_master_model_i.st(2, CMD_WRITE_SCR);
    tasc_master_model_i.st(3, 8'hf6);
    tasc_master_model_i.st(3, 8'he2);
    tasc_master_model_i.st(2, CMD_COPY_SCR);
    nv_hi = 8'hf6;
    nv_lo = 8'he2;
    test_measure(7684, 16'hffff);
    tasc_master_model_i.st(2, CMD_WRITE_SCR);
    tasc_master_model_i.st(3, 8'h11);
    tasc_master_model_i.st(3, 8'h22);
    tasc_master_model_i.st(2, CMD_RECALL);
    tasc_master_model_i.st(2, CMD_READ_SCR);
    read_scr(10);
    `CHK({rb[3], rb[2]}, {nv_lo, nv_hi})
    `CHK(rb[9], BYTE_ONES)
    tasc_master_model_i.st(2, CMD_READ_SCR);
    read_scr(2);
    tasc_master_model_i.st(0, 8'h00);
    read_scr(1);
    `CHK(rb[0], BYTE_ONES)
    // The bus reset revoked access; with ce low nothing may move at all.
    ce = 1'b0;
    tasc_master_model_i.st(2, CMD_CONVERT);
    `CHK({busy, cmd_refused}, 2'h0)
    ce = 1'b1;
    tasc_master_model_i.st(2, CMD_CONVERT);
    `CHK({busy, cmd_refused}, 2'h1)
    $display("test_triggers done");
  endtask

  // Main sequence: reset held 20 cycles, then each scenario in turn.
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    osc_ref = 1'b0;
    osc_gate = 1'b0;
    err_total = 0;
    cmp_count = 0;
    nv_hi = NV_HI_RST;
    nv_lo = NV_LO_RST;
    repeat (20) @(negedge clk);
    test_reset_rom();
    test_refuse();
    test_measure(0, 16'hff92);
    test_triggers();
    tally_and_finish();
  end
endmodule
